// file: sideband_consts.vh
// Constants for the processor sideband control block
`ifndef SIDEBAND_CONSTS_VH
`define SIDEBAND_CONSTS_VH
// Register byte offsets
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_MASK 12'h008
`define REG_CODES 12'h00c
`define REG_PURGE 12'h010
`define REG_FAULT 12'h014
`define REG_BOOT 12'h018
// Control register fields
`define CTRL_NE_BIT 0
`define CTRL_FP_UNMASK_BIT 1
`define CTRL_FP_RAISE_BIT 2
`define CTRL_FP_CLEAR_BIT 3
`define CTRL_INTERNAL_FAULT_OUT_RAISE_BIT 4
`define CTRL_SNOOP_STALL_BIT 5
// Status and mask fields
`define ST_PURGE_DONE 0
`define ST_FAULT 1
`define ST_FP_EXC 2
`define ST_RESTART 3
`define ST_WIDTH 4
// Purge register fields
`define PURGE_BUSY_BIT 0
`define PURGE_BLOCK_BIT 1
`define PURGE_STRAP_BIT 2
// Reset values
`define CTRL_RESET 32'h00000002
`define CODES_RESET 32'h0000001f
// Purge walk
`define PURGE_LINES 16
`define PURGE_IDX_W 4
// Purge state codes
`define PS_IDLE 2'h0
`define PS_WALK 2'h1
`define PS_ACK 2'h2
`define PS_HOLD 2'h3
`endif

// file: sync2.v
// Two-stage synchroniser for a group of asynchronous levels
`timescale 1ns/1ps
module sync2 #(
	parameter W = 3
)(
	input wire clk,
	input wire rst_n,
	input wire [W-1:0] d,
	output wire [W-1:0] q
);
	reg [W-1:0] meta_r;
	reg [W-1:0] sync_r;
	genvar i;
	// One pair of flops per bit; first stage feeds only the second
	generate
		for (i = 0; i < W; i = i + 1)
		begin : g_bit
			always @(posedge clk or negedge rst_n)
			begin
				if (!rst_n)
				begin
					meta_r[i] <= 1'b0;
					sync_r[i] <= 1'b0;
				end
				else
				begin
					meta_r[i] <= d[i];
					sync_r[i] <= meta_r[i];
				end
			end
		end
	endgenerate
	assign q = sync_r;
endmodule

// file: cpu_sideband_control.v
// Processor sideband control: straps, float error, purge, faults, restart
`timescale 1ns/1ps
`include "sideband_consts.vh"
// Function
// - Strap enable low tristates voltage and speed code outputs.
// - Float error output asserts on any unmasked floating-point error.
// - Purge request writes back modified lines then invalidates all lines.
// - After purge completes, issue a flush acknowledge transaction.
// - No new cache allocation while purge request stays asserted.
// - Purge request level sampled at reset release as configuration.
// - Snoop match with modified match together requests or extends stall.
// - Internal error asserts fault output with a shutdown transaction.
// - Fault output stays set until reset, reinitialise or soft restart.
// - Mask asserted: ignore numeric errors, keep executing float ops.
// - Mask deasserted: pending float error raises exception on next noncontrol op.
// - Mask has no effect while native numeric error bit set.
// - Soft restart resets integer state, keeps caches and float registers.
// - After soft restart resume at configured reset vector.
// - Snoops keep being serviced during soft restart.
// - Soft restart active at reset release requests built-in self-test.
module cpu_sideband_control #(
	parameter LINES = `PURGE_LINES,
	parameter [31:0] RESET_VECTOR = 32'hfffffff0
)(
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	output wire irq,
	input wire strap_output_enable,
	output wire [4:0] core_voltage_code_o,
	output wire [4:0] core_voltage_code_oe,
	output wire [1:0] bus_speed_code_o,
	output wire [1:0] bus_speed_code_oe,
	output reg float_error_out_n,
	input wire purge_request_n,
	input wire numeric_fault_mask_n,
	input wire soft_restart_n,
	input wire bus_reinitialise_n,
	input wire internal_error,
	input wire float_op_valid,
	input wire float_op_control,
	output reg float_exception,
	output reg cache_alloc_enable,
	output reg flush_ack_req,
	input wire flush_ack_done,
	output reg shutdown_req,
	output reg internal_fault_out_n,
	input wire snoop_match_in_n,
	input wire snoop_modified_match_in_n,
	output reg snoop_stall,
	input wire snoop_req,
	output reg snoop_ack,
	output reg integer_reset,
	output reg [31:0] restart_vector,
	output reg self_test_req
);
	reg [31:0] ctrl_r;
	reg [31:0] codes_r;
	reg [`ST_WIDTH-1:0] status_r;
	reg [`ST_WIDTH-1:0] mask_r;
	reg [1:0] pstate_r;
	reg [`PURGE_IDX_W-1:0] idx_r;
	reg [LINES-1:0] line_valid_r;
	reg [LINES-1:0] line_dirty_r;
	reg fp_pending_r;
	reg strap_purge_r;
	reg strap_bist_r;
	reg boot_seen_r;
	reg restart_d_r;
	reg fault_r;
	reg [`ST_WIDTH-1:0] set_ev;
	reg purge_done_ev;
	wire restart_ev;
	wire fp_exc_ev;
	wire [2:0] sync_q;
	wire purge_act;
	wire mask_act;
	wire restart_act;
	wire wr_en;
	wire rd_en;
	wire fp_unmasked;
	wire ne_bit;
	wire stall_req;
	integer k;

	// Purge, mask and restart pins are retimed before use, except that the strap capture samples purge and restart raw
	sync2 #(
		.W(3)
	) u_sync (
		.clk(pclk),
		.rst_n(presetn),
		.d({~soft_restart_n, ~numeric_fault_mask_n, ~purge_request_n}),
		.q(sync_q)
	);
	assign purge_act = sync_q[0];
	assign mask_act = sync_q[1];
	assign restart_act = sync_q[2];

	// APB: zero wait state, never errors
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign wr_en = psel & penable & pwrite;
	assign rd_en = psel & penable & ~pwrite;

	// Strap pins tristate while the enable is low
	assign core_voltage_code_o = codes_r[4:0];
	assign bus_speed_code_o = codes_r[9:8];
	assign core_voltage_code_oe = {5{strap_output_enable}};
	assign bus_speed_code_oe = {2{strap_output_enable}};

	assign ne_bit = ctrl_r[`CTRL_NE_BIT];
	assign fp_unmasked = ctrl_r[`CTRL_FP_UNMASK_BIT];
	assign stall_req = ~snoop_match_in_n & ~snoop_modified_match_in_n;
	assign irq = |(status_r & mask_r);

	// Register writes
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_r <= `CTRL_RESET;
			codes_r <= `CODES_RESET;
			mask_r <= {`ST_WIDTH{1'b0}};
		end
		else if (wr_en)
		begin
			case (paddr)
				`REG_CTRL: ctrl_r <= pwdata;
				`REG_MASK: mask_r <= pwdata[`ST_WIDTH-1:0];
				`REG_CODES: codes_r <= pwdata;
				default: ctrl_r <= ctrl_r;
			endcase
		end
	end

	// Read data latched in the setup phase; unmapped reads return zero
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h00000000;
		else if (psel && !penable)
			case (paddr)
				`REG_CTRL: prdata <= ctrl_r;
				`REG_STATUS: prdata <= {28'h0000000, status_r};
				`REG_MASK: prdata <= {28'h0000000, mask_r};
				`REG_CODES: prdata <= codes_r;
				`REG_PURGE: prdata <= {29'h00000000, strap_purge_r, purge_act,
					pstate_r != `PS_IDLE};
				`REG_FAULT: prdata <= {30'h00000000, fp_pending_r, fault_r};
				`REG_BOOT: prdata <= {31'h00000000, strap_bist_r};
				default: prdata <= 32'h00000000;
			endcase
	end

	// Sticky status; a new event wins over the read clear
	always @*
	begin
		set_ev = {`ST_WIDTH{1'b0}};
		set_ev[`ST_PURGE_DONE] = purge_done_ev;
		set_ev[`ST_FAULT] = shutdown_req;
		set_ev[`ST_FP_EXC] = fp_exc_ev;
		set_ev[`ST_RESTART] = restart_ev;
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			status_r <= {`ST_WIDTH{1'b0}};
		else if (rd_en && paddr == `REG_STATUS)
			status_r <= (status_r & ~prdata[`ST_WIDTH-1:0]) | set_ev; // Only reported bits clear
		else
			status_r <= status_r | set_ev;
	end

	// Straps caught on the first edge after reset release
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			boot_seen_r <= 1'b0;
			strap_purge_r <= 1'b0;
			strap_bist_r <= 1'b0;
			self_test_req <= 1'b0;
		end
		else if (!boot_seen_r)
		begin
			boot_seen_r <= 1'b1;
			strap_purge_r <= ~purge_request_n;
			strap_bist_r <= ~soft_restart_n;
			self_test_req <= ~soft_restart_n;
		end
		else
			self_test_req <= 1'b0;
	end

	// Soft restart: integer reset follows the level, vector loaded on the edge, caches untouched
	assign restart_ev = restart_act & ~restart_d_r;

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			restart_d_r <= 1'b0;
			integer_reset <= 1'b0;
			restart_vector <= 32'h00000000;
		end
		else
		begin
			restart_d_r <= restart_act;
			integer_reset <= restart_act;
			if (restart_ev)
				restart_vector <= RESET_VECTOR;
		end
	end

	// Snoops answered regardless of restart; stall on joint match
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			snoop_ack <= 1'b0;
			snoop_stall <= 1'b0;
		end
		else
		begin
			snoop_ack <= snoop_req;
			snoop_stall <= stall_req | ctrl_r[`CTRL_SNOOP_STALL_BIT];
		end
	end

	// Internal fault: held until reset, reinitialise or restart
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			fault_r <= 1'b0;
			internal_fault_out_n <= 1'b1;
			shutdown_req <= 1'b0;
		end
		else
		begin
			shutdown_req <= 1'b0;
			if (!bus_reinitialise_n || restart_act)
			begin
				fault_r <= 1'b0;
				internal_fault_out_n <= 1'b1;
			end
			else if ((internal_error || (wr_en && paddr == `REG_CTRL &&
				pwdata[`CTRL_INTERNAL_FAULT_OUT_RAISE_BIT])) && !fault_r)
			begin
				fault_r <= 1'b1;
				internal_fault_out_n <= 1'b0;
				shutdown_req <= 1'b1;
			end
		end
	end

	// Float error tracking and exception on noncontrol ops
	assign fp_exc_ev = float_op_valid & ~float_op_control & fp_pending_r &
		(ne_bit | ~mask_act);

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			fp_pending_r <= 1'b0;
			float_error_out_n <= 1'b1;
			float_exception <= 1'b0;
		end
		else
		begin
			float_exception <= fp_exc_ev;
			// Mask ignores the error only when native reporting is off
			if (wr_en && paddr == `REG_CTRL && pwdata[`CTRL_FP_CLEAR_BIT])
				fp_pending_r <= 1'b0;
			else if (wr_en && paddr == `REG_CTRL && pwdata[`CTRL_FP_RAISE_BIT])
				fp_pending_r <= 1'b1;
			else if (fp_exc_ev)
				fp_pending_r <= 1'b0;
			float_error_out_n <= ~(fp_pending_r & fp_unmasked);
		end
	end

	// Purge walk: write back dirty lines, invalidate, then acknowledge
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pstate_r <= `PS_IDLE;
			idx_r <= {`PURGE_IDX_W{1'b0}};
			line_valid_r <= {LINES{1'b0}};
			line_dirty_r <= {LINES{1'b0}};
			flush_ack_req <= 1'b0;
			purge_done_ev <= 1'b0;
			cache_alloc_enable <= 1'b0;
		end
		else
		begin
			purge_done_ev <= 1'b0;
			cache_alloc_enable <= ~purge_act;
			case (pstate_r)
				`PS_IDLE:
				begin
					// Model allocation fills while allowed
					if (!purge_act && float_op_valid)
					begin
						for (k = 0; k < LINES; k = k + 1)
						begin
							if (idx_r == k[`PURGE_IDX_W-1:0])
							begin
								line_valid_r[k] <= 1'b1;
								line_dirty_r[k] <= 1'b1;
							end
						end
						idx_r <= idx_r + 1'b1;
					end
					if (purge_act)
					begin
						idx_r <= {`PURGE_IDX_W{1'b0}};
						pstate_r <= `PS_WALK;
					end
				end
				`PS_WALK:
				begin
					// One line per cycle: cleaned and invalidated on the same edge
					for (k = 0; k < LINES; k = k + 1)
					begin
						if (idx_r == k[`PURGE_IDX_W-1:0])
						begin
							line_dirty_r[k] <= 1'b0;
							line_valid_r[k] <= 1'b0;
						end
					end
					idx_r <= idx_r + 1'b1;
					if (idx_r == LINES - 1)
					begin
						pstate_r <= `PS_ACK;
						flush_ack_req <= 1'b1;
					end
				end
				`PS_ACK:
				begin
					if (flush_ack_done)
					begin
						flush_ack_req <= 1'b0;
						purge_done_ev <= 1'b1;
						pstate_r <= `PS_HOLD;
					end
				end
				`PS_HOLD:
				begin
					// Wait for request release; one purge per assertion
					if (!purge_act)
						pstate_r <= `PS_IDLE;
				end
				default: pstate_r <= `PS_IDLE;
			endcase
		end
	end
endmodule

// file: cpu_sideband_control_sva.sv
// Assertion checker for the sideband control block
`timescale 1ns/1ps
module sideband_sva #(
	parameter [31:0] RESET_VECTOR = 32'hfffffff0
)(
	input wire pclk,
	input wire presetn,
	input wire strap_output_enable,
	input wire [4:0] core_voltage_code_oe,
	input wire [1:0] bus_speed_code_oe,
	input wire internal_error,
	input wire internal_fault_out_n,
	input wire bus_reinitialise_n,
	input wire soft_restart_n,
	input wire integer_reset,
	input wire snoop_match_in_n,
	input wire snoop_modified_match_in_n,
	input wire snoop_stall,
	input wire snoop_req,
	input wire snoop_ack,
	input wire purge_request_n,
	input wire cache_alloc_enable,
	input wire flush_ack_req,
	input wire flush_ack_done,
	input wire [31:0] restart_vector
);
	// One domain, so one clock and one reset for all
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// Strap codes are only driven while the enable pin is high
	oe_follow_a: assert property (core_voltage_code_oe == {5{strap_output_enable}} &&
		bus_speed_code_oe == {2{strap_output_enable}}) else $error("strap enable");
	// Restart is excluded: it clears the fault in the same window
	fault_set_a: assert property (internal_error && bus_reinitialise_n && soft_restart_n &&
		!integer_reset |=> !internal_fault_out_n) else $error("fault set");
	fault_hold_a: assert property (!internal_fault_out_n && bus_reinitialise_n &&
		soft_restart_n && !integer_reset |=> !internal_fault_out_n) else $error("fault hold");
	stall_req_a: assert property (!snoop_match_in_n && !snoop_modified_match_in_n
		|=> snoop_stall) else $error("snoop stall");
	snoop_ack_a: assert property (snoop_req |=> snoop_ack) else $error("snoop ack");
	// Sync depth plus register: four low samples must block allocation
	alloc_block_a: assert property (!purge_request_n [*4] |-> !cache_alloc_enable)
		else $error("alloc block");
	ack_hold_a: assert property (flush_ack_req && !flush_ack_done |=> flush_ack_req)
		else $error("ack hold");
	// The line walk keeps the acknowledge back for at least fifteen cycles
	purge_walk_a: assert property ($rose(flush_ack_req) |-> !$past(cache_alloc_enable, 15))
		else $error("purge walk");
	restart_vec_a: assert property (integer_reset [*2] |-> restart_vector == RESET_VECTOR)
		else $error("restart vector");
endmodule
bind cpu_sideband_control sideband_sva #(.RESET_VECTOR(RESET_VECTOR)) chk (.*);

// file: sideband_partner.sv
// Core logic model: flush acknowledge, snoop traffic and stall lines
`timescale 1ns/1ps
module sideband_partner (
	input wire pclk,
	input wire presetn,
	input wire flush_ack_req,
	input wire stall_cmd,
	output logic flush_ack_done,
	output logic snoop_req,
	output wire snoop_match_in_n,
	output wire snoop_modified_match_in_n
);
	logic [2:0] cnt;
	// Varying pause before acknowledging; snoops keep coming regardless
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt <= 3'h0;
			flush_ack_done <= 1'b0;
			snoop_req <= 1'b0;
		end
		else
		begin
			cnt <= cnt + 3'h1;
			snoop_req <= cnt[0];
			flush_ack_done <= flush_ack_req && !flush_ack_done && cnt[1];
		end
	end
	// Stall only ever shown on both lines together
	assign snoop_match_in_n = !stall_cmd;
	assign snoop_modified_match_in_n = !stall_cmd;
endmodule

// file: test_cpu_sideband_control.sv
// Self-checking bench for the sideband control block
`timescale 1ns/1ps
`include "sideband_consts.vh"
module test_cpu_sideband_control;
	localparam [31:0] RV = 32'h00c0ffe0;
	logic pclk, presetn = 0, psel = 0, penable = 0, pwrite = 0, stall_cmd = 0, seen, slv;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000, rd;
	logic strap_output_enable = 1, purge_request_n = 1, numeric_fault_mask_n = 1;
	logic soft_restart_n = 0, bus_reinitialise_n = 1, internal_error = 0;
	logic float_op_valid = 0, float_op_control = 0;
	wire [31:0] prdata, restart_vector;
	wire [4:0] core_voltage_code_o, core_voltage_code_oe;
	wire [1:0] bus_speed_code_o, bus_speed_code_oe;
	wire pready, irq, float_error_out_n, float_exception, cache_alloc_enable, flush_ack_req;
	wire flush_ack_done, internal_fault_out_n, snoop_match_in_n, snoop_modified_match_in_n;
	wire snoop_req, integer_reset, self_test_req;
	wire pslverr, shutdown_req, snoop_stall, snoop_ack;
	int errors = 0, checked = 0;

	cpu_sideband_control #(.RESET_VECTOR(RV)) dut (.*);
	sideband_partner peer (.*);

	// Bus clock, 50 ns period
	initial
	begin
		pclk = 0;
		forever #25 pclk = ~pclk;
	end

	task automatic final_report;
		if (errors == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
		checked++;
		if (e !== s)
		begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask

	// One transfer plus an idle edge, so calls may follow back to back
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		for (i = 0; i < 16; i++)
		begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		rd = prdata;
		slv = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
		if (i == 16)
		begin
			errors++;
			final_report();
		end
	endtask

	// Exception seen within three edges of one operation
	task automatic fop(input string n, input logic c, input logic e);
		seen = 0;
		float_op_valid <= 1;
		float_op_control <= c;
		@(posedge pclk);
		float_op_valid <= 0;
		repeat (3)
		begin
			@(posedge pclk);
			seen |= float_exception;
		end
		cmp(n, e, seen);
	endtask

	task automatic t_regs;
		apb(0, `REG_STATUS, 0);
		apb(0, `REG_CTRL, 0);
		cmp("ctrl", `CTRL_RESET, rd);
		apb(0, `REG_CODES, 0);
		cmp("codes", `CODES_RESET, rd);
		apb(1, 12'h100, 32'hffffffff);
		apb(0, 12'h100, 0);
		cmp("unmapped", 0, rd);
		cmp("slverr", 0, slv);
		apb(0, `REG_BOOT, 0);
		cmp("bist_strap", 1, rd);
		apb(0, `REG_PURGE, 0);
		cmp("purge_strap", 0, rd);
		strap_output_enable <= 0;
		repeat (2) @(posedge pclk);
		cmp("oe_off", 0, {core_voltage_code_oe, bus_speed_code_oe});
		strap_output_enable <= 1;
		apb(1, `REG_CODES, 32'h0000020a);
		cmp("oe_on", 7'h7f, {core_voltage_code_oe, bus_speed_code_oe});
		cmp("code_out", 7'h2a, {core_voltage_code_o, bus_speed_code_o});
	endtask

	task automatic t_fault;
		apb(1, `REG_MASK, 0);
		apb(1, `REG_CTRL, 32'h00000012);
		cmp("irq_masked", 0, irq);
		apb(1, `REG_MASK, 32'h0000000f);
		cmp("irq_on", 1, irq);
		apb(0, `REG_STATUS, 0);
		cmp("status_fault", 32'h2, rd);
		cmp("irq_off", 0, irq);
		cmp("fault_held", 0, internal_fault_out_n);
		apb(0, `REG_FAULT, 0);
		cmp("fault_reg", 32'h1, rd);
		bus_reinitialise_n <= 0;
		@(posedge pclk);
		bus_reinitialise_n <= 1;
		repeat (2) @(posedge pclk);
		cmp("fault_clear", 1, internal_fault_out_n);
	endtask

	task automatic t_purge;
		int i;
		purge_request_n <= 0;
		for (i = 0; i < 40 && flush_ack_req !== 1'b1; i++)
			@(posedge pclk);
		cmp("purge_ack", 1, flush_ack_req);
		cmp("walk_len", 1, i >= `PURGE_LINES + 2);
		cmp("alloc_off", 0, cache_alloc_enable);
		for (i = 0; i < 12 && flush_ack_req === 1'b1; i++)
			@(posedge pclk);
		cmp("ack_drop", 0, flush_ack_req);
		apb(0, `REG_STATUS, 0);
		cmp("status_purge", 32'h1, rd);
		cmp("alloc_held", 0, cache_alloc_enable);
		apb(0, `REG_PURGE, 0);
		cmp("purge_busy", 32'h3, rd);
		purge_request_n <= 1;
		repeat (5) @(posedge pclk);
		cmp("alloc_on", 1, cache_alloc_enable);
	endtask

	task automatic t_float;
		apb(1, `REG_CTRL, 32'h00000006);
		repeat (2) @(posedge pclk);
		cmp("float_err", 0, float_error_out_n);
		numeric_fault_mask_n <= 0;
		repeat (4) @(posedge pclk);
		fop("ignored", 0, 0);
		numeric_fault_mask_n <= 1;
		repeat (4) @(posedge pclk);
		fop("control_op", 1, 0);
		fop("raised", 0, 1);
		apb(1, `REG_CTRL, 32'h00000007);
		numeric_fault_mask_n <= 0;
		repeat (4) @(posedge pclk);
		fop("ne_set", 0, 1);
		apb(1, `REG_CTRL, 32'h00000002);
	endtask

	task automatic t_restart;
		internal_error <= 1;
		@(posedge pclk);
		internal_error <= 0;
		stall_cmd <= 1;
		@(posedge pclk);
		cmp("shutdown", 1, shutdown_req);
		repeat (2) @(posedge pclk);
		cmp("stall", 1, snoop_stall);
		stall_cmd <= 0;
		apb(1, `REG_CTRL, 32'h00000022);
		@(posedge pclk);
		cmp("stall_force", 1, snoop_stall);
		apb(1, `REG_CTRL, 32'h00000002);
		soft_restart_n <= 0;
		repeat (5) @(posedge pclk);
		seen = snoop_req;
		@(posedge pclk);
		cmp("snoop_ack", seen, snoop_ack);
		cmp("int_reset", 1, integer_reset);
		cmp("vector", RV, restart_vector);
		cmp("restart_clr", 1, internal_fault_out_n);
		soft_restart_n <= 1;
		repeat (6) @(posedge pclk);
		cmp("int_release", 0, integer_reset);
	endtask

	// Reset, self-test strap, then each scenario in turn
	initial
	begin
		repeat (10) @(posedge pclk);
		presetn <= 1;
		repeat (2) @(posedge pclk);
		cmp("self_test", 1, self_test_req);
		soft_restart_n <= 1;
		repeat (6) @(posedge pclk);
		t_regs();
		t_fault();
		t_purge();
		t_float();
		t_restart();
		final_report();
	end
endmodule
